// [verilog/nfh_map.vh]
// Constants for the NAND flash pin-level host controller.
// Assumes a 200 MHz clock; all times in ns, counts in clock cycles.
`ifndef NFH_MAP_VH
`define NFH_MAP_VH

`define NFH_CLK_NS 5
// Write strobe low time and high time
`define NFH_T_WP_NS 25
`define NFH_T_WH_NS 25
`define NFH_WP_CYC ((`NFH_T_WP_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_WH_CYC ((`NFH_T_WH_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
// Output strobe low time and high time
`define NFH_T_RP_NS 30
`define NFH_T_REH_NS 20
`define NFH_RP_CYC ((`NFH_T_RP_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_REH_CYC ((`NFH_T_REH_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
// Write strobe high to busy, and write high to output strobe low
`define NFH_T_WB_NS 100
`define NFH_WB_CYC ((`NFH_T_WB_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_T_WHR_NS 60
`define NFH_WHR_CYC ((`NFH_T_WHR_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
// Chip select high hold to break a sequential read
`define NFH_T_CEH_NS 100
`define NFH_CEH_CYC ((`NFH_T_CEH_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)

// Request kinds on the user port
`define NFH_OP_CMD 2'h0
`define NFH_OP_ADDR 2'h1
`define NFH_OP_WDATA 2'h2
`define NFH_OP_RDATA 2'h3

// Command codes
`define NFH_CMD_READ1A 8'h00
`define NFH_CMD_READ1B 8'h01
`define NFH_CMD_READ2 8'h50
`define NFH_CMD_ERASE1 8'h60
`define NFH_CMD_ERASE2 8'hd0
`define NFH_CMD_PROG1 8'h80
`define NFH_CMD_PROG2 8'h10

`endif

// [verilog/nfh_buf2.v]
// Two-entry valid/ready buffer for read data bytes.
// Assumes one clock; drain side may stall at any time.
`timescale 1ns/1ps
module nfh_buf2 (
	input wire clk,
	input wire resetn,
	input wire in_valid,
	output wire in_ready,
	input wire [7:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [7:0] out_data
);
	reg [7:0] mem [0:1];
	reg wr_ptr;
	reg rd_ptr;
	reg [1:0] count;
	wire push;
	wire pop;

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always @(posedge clk) begin
		if (!resetn) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
			mem[0] <= 8'h00;
			mem[1] <= 8'h00;
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= ~wr_ptr;
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push && !pop)
				count <= count + 2'h1;
			else if (pop && !push)
				count <= count - 2'h1;
		end
	end
endmodule // nfh_buf2

// [verilog/nfh_host.v]
// Host controller driving a byte-wide NAND flash over its pins.
// Assumes flash pins are synchronous to clk; read bytes leave via a buffer.
// Behaviour
// - Command cycles: command strobe high, write pulse
// - Address cycles: address strobe high, write pulse
// - Spare deselect held low unless chosen
// - Never program or erase invalid blocks other than block 0
// - Address as column, low row, high row
// - Erase is setup, rows, execute command
`timescale 1ns/1ps
`include "nfh_map.vh"
module nfh_host (
	input wire clk,
	input wire resetn,
	input wire req_valid,
	output wire req_ready,
	input wire [1:0] req_op,
	input wire [7:0] req_data,
	input wire req_last,
	input wire spare_off,
	input wire [9:0] bad_block,
	input wire bad_block_hit,
	output wire rd_valid,
	input wire rd_ready,
	output wire [7:0] rd_data,
	output reg refused,
	output wire flash_ready,
	output reg cmd_latch,
	output reg addr_latch,
	output reg chip_sel_n,
	output reg write_strobe_n,
	output reg output_strobe_n,
	output reg write_guard_n,
	output reg spare_desel,
	input wire [7:0] shared_port_lines_in,
	output reg [7:0] shared_port_lines_out,
	output reg shared_port_lines_oe,
	input wire ready_busy_in
);
	localparam ST_IDLE = 3'h0;
	localparam ST_WLOW = 3'h1;
	localparam ST_WHIGH = 3'h2;
	localparam ST_RWAIT = 3'h3;
	localparam ST_RLOW = 3'h4;
	localparam ST_RHIGH = 3'h5;
	localparam ST_DESEL = 3'h6;
	// Counter loads, one less than the cycles each phase lasts
	localparam [7:0] WP_LOAD = `NFH_WP_CYC - 1;
	localparam [7:0] WH_LOAD = `NFH_WH_CYC - 1;
	localparam [7:0] RP_LOAD = `NFH_RP_CYC - 1;
	localparam [7:0] REH_LOAD = `NFH_REH_CYC - 1;
	localparam [7:0] WB_LOAD = `NFH_WB_CYC - 1;
	localparam [7:0] WHR_LOAD = `NFH_WHR_CYC - 1;
	localparam [7:0] CEH_LOAD = `NFH_CEH_CYC - 1;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [7:0] cnt;
	reg [1:0] addr_idx;
	reg erase_seq;
	reg prog_seq;
	reg [7:0] row_low;
	reg last_op;
	reg cap_valid;
	reg [7:0] cap_data;
	wire cap_ready;

	// Decodes a command byte that begins or ends a write sequence
	function is_write_cmd;
		input [7:0] c;
		begin
			is_write_cmd = (c == `NFH_CMD_PROG1) ||
				(c == `NFH_CMD_ERASE1) || (c == `NFH_CMD_PROG2) ||
				(c == `NFH_CMD_ERASE2);
		end
	endfunction

	// Block address from the two row bytes (row bits A14..A23)
	wire [9:0] cur_block = {req_data[6:0], row_low[7:5]};
	wire blk_bad = bad_block_hit && (cur_block == bad_block) &&
		(cur_block != 10'h000);
	wire idle = (state == ST_IDLE);
	wire rd_pend = (req_op == `NFH_OP_RDATA);
	assign req_ready = idle && (!rd_pend || cap_ready) &&
		(rd_pend ? ready_busy_in : 1'b1);
	wire take = req_valid && req_ready;
	// Refuse the row byte that names a known invalid block
	// Erase names the block at its second byte, program at its third
	wire bad_row = (req_op == `NFH_OP_ADDR) && blk_bad &&
		((erase_seq && addr_idx == 2'h1) ||
		(prog_seq && addr_idx == 2'h2));
	assign flash_ready = ready_busy_in;

	nfh_buf2 u_buf (
		.clk(clk),
		.resetn(resetn),
		.in_valid(cap_valid),
		.in_ready(cap_ready),
		.in_data(cap_data),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// ----------------------------------------------------------
	// Pin sequencer
	// ----------------------------------------------------------
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (take && !bad_row)
				next_state = rd_pend ? ST_RWAIT : ST_WLOW;
		end
		ST_WLOW: begin
			if (cnt == 8'h00)
				next_state = ST_WHIGH;
		end
		ST_WHIGH: begin
			if (cnt == 8'h00)
				next_state = ST_IDLE;
		end
		ST_RWAIT: begin
			if (cnt == 8'h00)
				next_state = ST_RLOW;
		end
		ST_RLOW: begin
			if (cnt == 8'h00)
				next_state = ST_RHIGH;
		end
		ST_RHIGH: begin
			if (cnt == 8'h00)
				next_state = last_op ? ST_DESEL : ST_IDLE;
		end
		ST_DESEL: begin
			if (cnt == 8'h00)
				next_state = ST_IDLE;
		end
		default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			cnt <= 8'h00;
			addr_idx <= 2'h0;
			erase_seq <= 1'b0;
			prog_seq <= 1'b0;
			row_low <= 8'h00;
			last_op <= 1'b0;
			cap_valid <= 1'b0;
			cap_data <= 8'h00;
			refused <= 1'b0;
			cmd_latch <= 1'b0;
			addr_latch <= 1'b0;
			chip_sel_n <= 1'b1;
			write_strobe_n <= 1'b1;
			output_strobe_n <= 1'b1;
			write_guard_n <= 1'b0;
			spare_desel <= 1'b0;
			shared_port_lines_out <= 8'h00;
			shared_port_lines_oe <= 1'b0;
		end else begin
			state <= next_state;
			cap_valid <= 1'b0;
			refused <= 1'b0;
			if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
			case (state)
			ST_IDLE: begin
				if (take && bad_row) begin
					refused <= 1'b1;
					erase_seq <= 1'b0;
					prog_seq <= 1'b0;
					addr_idx <= 2'h0;
				end else if (take) begin
					chip_sel_n <= 1'b0;
					last_op <= req_last;
					spare_desel <= spare_off;
					if (rd_pend) begin
						cmd_latch <= 1'b0;
						addr_latch <= 1'b0;
						shared_port_lines_oe <= 1'b0;
						cnt <= WHR_LOAD;
					end else begin
						cmd_latch <= (req_op == `NFH_OP_CMD);
						addr_latch <= (req_op == `NFH_OP_ADDR);
						write_strobe_n <= 1'b0;
						shared_port_lines_out <= req_data;
						shared_port_lines_oe <= 1'b1;
						cnt <= WP_LOAD;
					end
					if (req_op == `NFH_OP_CMD) begin
						addr_idx <= 2'h0;
						if (req_data == `NFH_CMD_ERASE1)
							erase_seq <= 1'b1;
						else if (req_data == `NFH_CMD_PROG1)
							prog_seq <= 1'b1;
						else if (!is_write_cmd(req_data)) begin
							erase_seq <= 1'b0;
							prog_seq <= 1'b0;
						end
						write_guard_n <= is_write_cmd(req_data) ||
							erase_seq || prog_seq;
					end else if (req_op == `NFH_OP_ADDR) begin
						if (addr_idx != 2'h3)
							addr_idx <= addr_idx + 2'h1;
						if (addr_idx == (erase_seq ? 2'h0 : 2'h1))
							row_low <= req_data;
					end
				end
			end
			ST_WLOW: begin
				if (cnt == 8'h00) begin
					write_strobe_n <= 1'b1;
					cnt <= WH_LOAD;
				end
			end
			ST_WHIGH: begin
				if (cnt == 8'h00) begin
					cmd_latch <= 1'b0;
					addr_latch <= 1'b0;
					shared_port_lines_oe <= 1'b0;
					// Final erase/program command ends the sequence
					if (cmd_latch && (shared_port_lines_out ==
						`NFH_CMD_ERASE2 || shared_port_lines_out ==
						`NFH_CMD_PROG2)) begin
						erase_seq <= 1'b0;
						prog_seq <= 1'b0;
						cnt <= WB_LOAD;
						state <= ST_DESEL;
					end else if (last_op) begin
						cnt <= CEH_LOAD;
						state <= ST_DESEL;
					end
				end
			end
			ST_RWAIT: begin
				if (cnt == 8'h00) begin
					output_strobe_n <= 1'b0;
					cnt <= RP_LOAD;
				end
			end
			ST_RLOW: begin
				if (cnt == 8'h00) begin
					output_strobe_n <= 1'b1;
					cap_data <= shared_port_lines_in;
					cap_valid <= 1'b1;
					cnt <= last_op ? CEH_LOAD : REH_LOAD;
				end
			end
			ST_RHIGH: begin
				if (cnt == 8'h00 && last_op)
					chip_sel_n <= 1'b1;
			end
			ST_DESEL: begin
				// Chip select high is harmless during busy
				chip_sel_n <= 1'b1;
			end
			default: ;
			endcase
		end
	end
endmodule // nfh_host

// [sim/nfh_host_sva.sv]
// Pin-level checks on the flash host controller.
// Assumes it is bound onto nfh_host.
`timescale 1ns/1ps
module nfh_host_sva (
	input wire clk,
	input wire resetn,
	input wire cmd_latch,
	input wire addr_latch,
	input wire write_strobe_n,
	input wire output_strobe_n,
	input wire [7:0] shared_port_lines_out,
	input wire shared_port_lines_oe,
	input wire flash_ready,
	input wire ready_busy_in
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
latch_clash_a: assert property (!(cmd_latch && addr_latch))
	else $error("both latch strobes high");
strobe_clash_a: assert property (!(!write_strobe_n && !output_strobe_n))
	else $error("write and output strobes both low");
write_low_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n[*5])
	else $error("write strobe low too short");
write_high_a: assert property ($rose(write_strobe_n) |-> write_strobe_n[*5])
	else $error("write strobe high too short");
read_low_a: assert property ($fell(output_strobe_n) |-> !output_strobe_n[*6])
	else $error("output strobe low too short");
latch_hold_a: assert property ($rose(write_strobe_n) |-> $stable(cmd_latch) && $stable(addr_latch) && $stable(shared_port_lines_out) && shared_port_lines_oe)
	else $error("byte or latch moved at write edge");
port_float_a: assert property (!output_strobe_n |-> !shared_port_lines_oe)
	else $error("host drives port during read");
busy_pass_a: assert property (flash_ready == ready_busy_in)
	else $error("ready flag differs from pin");
endmodule // nfh_host_sva

// [sim/nfh_dev.sv]
// Behavioural flash device on the host's pins.
// Assumes a pull-up on ready/busy; busy time counted in clk cycles.
`timescale 1ns/1ps
module nfh_dev #(parameter BUSY = 40) (
	input wire clk,
	input wire chip_sel_n,
	input wire cmd_latch,
	input wire addr_latch,
	input wire write_strobe_n,
	input wire output_strobe_n,
	input wire write_guard_n,
	input wire [7:0] host_out,
	input wire host_oe,
	output wire [7:0] lines,
	output wire rb
);
reg [7:0] cmd = 8'hff, col = 8'h00, rd = 8'h00, wd = 8'h00;
reg [7:0] a [0:3];
reg gd = 0;
reg half = 0;
integer n = 0, busy = 0;
assign lines = host_oe ? host_out : (!chip_sel_n && !output_strobe_n) ? rd : ~rd;
assign rb = (busy == 0);
always @(posedge write_strobe_n) begin
	if (!chip_sel_n && cmd_latch) begin
		cmd <= lines;
		half <= (lines == 8'h01);
		n <= 0;
		gd <= write_guard_n;
		if (write_guard_n && (lines == 8'h10 || lines == 8'hd0))
			busy <= BUSY;
	end else if (!chip_sel_n && addr_latch) begin
		a[n & 3] <= lines;
		if (n == 0)
			col <= lines;
		n <= n + 1;
	end else if (!chip_sel_n) begin
		wd <= lines;
	end
end
always @(negedge output_strobe_n) begin
	if (!chip_sel_n) begin
		rd <= col ^ (half ? 8'hc3 : 8'h3c);
		col <= col + 8'h01;
	end
end
always @(posedge clk) if (busy > 0) busy <= busy - 1;
endmodule // nfh_dev

// [sim/nfh_host_tb.sv]
// Self-checking bench for nfh_host with a device model.
// Assumes nfh_dev and nfh_host_sva are compiled first.
`timescale 1ns/1ps
module nfh_host_tb;
reg clk = 0, resetn = 0, req_valid = 0, req_last = 0, rd_ready = 0, hit = 0;
reg spare = 0;
wire spare_desel;
reg [1:0] req_op = 0;
reg [7:0] req_data = 0;
reg [9:0] bad = 0;
wire req_ready, rd_valid, refused, flash_ready, cmd_latch, addr_latch, oe;
wire chip_sel_n, write_strobe_n, output_strobe_n, write_guard_n, rb;
wire [7:0] rd_data, port_out, lines;
integer mismatches = 0, checked = 0, refusals = 0, k;
reg [7:0] got [$];
initial forever #2.5 clk = ~clk;
always @(posedge clk) if (refused === 1'b1) refusals = refusals + 1;
always @(posedge clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) got.push_back(rd_data);
nfh_host i_dut (.clk(clk), .resetn(resetn), .req_valid(req_valid),
	.req_ready(req_ready), .req_op(req_op), .req_data(req_data),
	.req_last(req_last), .spare_off(spare), .bad_block(bad),
	.bad_block_hit(hit), .rd_valid(rd_valid), .rd_ready(rd_ready),
	.rd_data(rd_data), .refused(refused), .flash_ready(flash_ready),
	.cmd_latch(cmd_latch), .addr_latch(addr_latch), .chip_sel_n(chip_sel_n),
	.write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
	.write_guard_n(write_guard_n), .spare_desel(spare_desel),
	.shared_port_lines_in(lines), .shared_port_lines_out(port_out),
	.shared_port_lines_oe(oe), .ready_busy_in(rb));
nfh_dev i_dev (.clk(clk), .chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
	.addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
	.output_strobe_n(output_strobe_n), .write_guard_n(write_guard_n),
	.host_out(port_out), .host_oe(oe), .lines(lines), .rb(rb));
task chk(input string w, input [7:0] e, input [7:0] g);
	begin
		checked = checked + 1;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", w, e, g);
			mismatches = mismatches + 1;
		end
	end
endtask
task send(input [1:0] op, input [7:0] d, input l);
	integer i;
	begin
		@(negedge clk);
		req_valid = 1;
		req_op = op;
		req_data = d;
		req_last = l;
		#1;
		for (i = 0; i < 300 && req_ready !== 1'b1; i = i + 1)
			@(negedge clk);
		@(negedge clk);
		req_valid = 0;
	end
endtask
task wait_rb(input e);
	integer i;
	begin
		for (i = 0; i < 200 && flash_ready !== e; i = i + 1)
			@(negedge clk);
		chk("ready", {7'h00, e}, {7'h00, flash_ready});
	end
endtask
task t_read;
	begin
		send(0, 8'h00, 0);
		send(1, 8'h05, 0);
		send(1, 8'h12, 0);
		send(1, 8'h01, 0);
		send(3, 8'h00, 0);
		chk("cmd", 8'h00, i_dev.cmd);
		chk("row", 8'h12, i_dev.a[1]);
		chk("row", 8'h01, i_dev.a[2]);
		send(3, 8'h00, 0);
		repeat (40) @(negedge clk);
		req_op = 3;
		#1;
		chk("room", 8'h00, {7'h00, req_ready});
		rd_ready = 1;
		spare = 1;
		send(3, 8'h00, 1);
		chk("spare", 8'h01, {7'h00, spare_desel});
		spare = 0;
		repeat (40) @(negedge clk);
		chk("count", 8'h03, got.size());
		for (k = 0; k < 3; k = k + 1)
			chk("byte", (8'h05 + k) ^ 8'h3c, got[k]);
		chk("empty", 8'h00, {7'h00, rd_valid});
		chk("desel", 8'h01, {7'h00, chip_sel_n});
		send(0, 8'h01, 0);
		send(1, 8'h00, 0);
		send(1, 8'h00, 0);
		send(1, 8'h00, 0);
		send(3, 8'h00, 1);
		repeat (40) @(negedge clk);
		chk("half", 8'hc3, got[3]);
	end
endtask
task t_prog;
	begin
		hit = 1;
		send(0, 8'h80, 0);
		send(1, 8'h00, 0);
		send(1, 8'h00, 0);
		send(1, 8'h00, 0);
		send(2, 8'ha5, 0);
		send(0, 8'h10, 0);
		chk("refuse", 8'h00, refusals[7:0]);
		chk("data", 8'ha5, i_dev.wd);
		chk("spare", 8'h00, {7'h00, spare_desel});
		wait_rb(0);
		chk("guard", 8'h01, {7'h00, i_dev.gd});
		wait_rb(1);
	end
endtask
task t_bad;
	begin
		bad = 10'h003;
		send(0, 8'h80, 0);
		send(1, 8'h00, 0);
		send(1, 8'h60, 0);
		send(1, 8'h00, 0);
		send(0, 8'h60, 0);
		chk("refuse", 8'h01, refusals[7:0]);
		send(1, 8'h20, 0);
		send(1, 8'h00, 0);
		send(0, 8'hd0, 0);
		chk("row", 8'h20, i_dev.a[0]);
		wait_rb(0);
		chk("cmd", 8'hd0, i_dev.cmd);
		wait_rb(1);
	end
endtask
task complete_run;
	begin
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
endtask
initial begin
	#100000;
	mismatches = mismatches + 1;
	complete_run;
end
initial begin
	repeat (2) @(negedge clk);
	resetn = 1;
	t_read;
	t_prog;
	t_bad;
	complete_run;
end
endmodule // nfh_host_tb
bind nfh_host nfh_host_sva i_sva (.clk(clk), .resetn(resetn),
	.cmd_latch(cmd_latch), .addr_latch(addr_latch),
	.write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
	.shared_port_lines_out(shared_port_lines_out),
	.shared_port_lines_oe(shared_port_lines_oe),
	.flash_ready(flash_ready), .ready_busy_in(ready_busy_in));
